// *** inc/charge_seq_map.vh ***
`ifndef CHARGE_SEQ_MAP_VH
`define CHARGE_SEQ_MAP_VH

// Clock rate and base tick (1 us)
`define CLK_MHZ            125
`define US_CYCLES          125

// Timer figures, in their own units
`define OVPZ_DGL_MS        30
`define SLEEP_DGL_US       64
`define VIN_WAKE_MS        10
`define REC_SC_MS          250
`define RETRY_SC_MS        2000
`define BATTERY_UNDERVOLTAGE_LEVEL_DGL_US       60
`define TS_ON_MS           4
`define TS_OFF_MS          196
`define WDOG_SHORT_S       40
`define WDOG_LONG_S        160
`define I2C_IDLE_MS        500
`define SHIP_WAKE_MS       2000

// Watchdog select encodings
`define WDOG_SEL_40S       2'h0
`define WDOG_SEL_160S      2'h1

// Termination select encodings
`define TERM_SEL_OFF       2'h0
`define TERM_SEL_5PCT      2'h1
`define TERM_SEL_10PCT     2'h2
`define TERM_SEL_20PCT     2'h3

// Regulation voltage code, 10 mV steps above 3.5 V; 4.65 V clamp
`define VREG_CODE_MAX      7'h73

// Precharge share of safety timer, as a right shift (25 %)
`define PRECHG_SHIFT       2

// Reset values
`define SAFETY_MIN_RST     10'h0B4

`endif

// *** hdl/tick_gen.v ***
`timescale 1ns/1ps
`include "charge_seq_map.vh"

// Divides the clock down to 1 us and 1 ms enable pulses
module tick_gen (
  input  wire clock_i,
  input  wire rst_i,
  output reg  us_tick_o,
  output reg  ms_tick_o
);

  localparam [6:0] US_LAST = `US_CYCLES - 1;
  localparam [9:0] MS_LAST = 10'h3E7;

  reg [6:0] us_cnt_q;
  reg [9:0] ms_cnt_q;

  // Microsecond and millisecond dividers
  always @(posedge clock_i) begin
    us_tick_o <= 1'b0;
    ms_tick_o <= 1'b0;
    if (rst_i) begin
      us_cnt_q <= 7'h00;
      ms_cnt_q <= 10'h000;
    end else if (us_cnt_q == US_LAST) begin
      us_cnt_q  <= 7'h00;
      us_tick_o <= 1'b1;
      if (ms_cnt_q == MS_LAST) begin
        ms_cnt_q  <= 10'h000;
        ms_tick_o <= 1'b1;
      end else begin
        ms_cnt_q <= ms_cnt_q + 10'h001;
      end
    end else begin
      us_cnt_q <= us_cnt_q + 7'h01;
    end
  end

endmodule

// *** hdl/deglitch.v ***
`timescale 1ns/1ps

// Output follows input only after it has held steady for LEN ticks
module deglitch #(
  parameter [19:0] LEN = 20'h00001
) (
  input  wire clock_i,
  input  wire rst_i,
  input  wire tick_i,
  input  wire level_i,
  output reg  level_o
);

  reg [19:0] cnt_q;

  // Any return to agreement restarts the qualifying count
  always @(posedge clock_i) begin
    if (rst_i) begin
      cnt_q   <= 20'h00000;
      level_o <= 1'b0;
    end else if (level_i == level_o) begin
      cnt_q <= 20'h00000;
    end else if (tick_i) begin
      if (cnt_q >= LEN - 20'h00001) begin
        level_o <= level_i;
        cnt_q   <= 20'h00000;
      end else begin
        cnt_q <= cnt_q + 20'h00001;
      end
    end
  end

endmodule

// *** hdl/linear_charge_sequencer.v ***
`timescale 1ns/1ps
`include "charge_seq_map.vh"

module linear_charge_sequencer (
  input  wire       clock_i,
  input  wire       rst_i,
  input  wire       vin_above_loop_i,
  input  wire       vin_above_sleep_i,
  input  wire       vin_below_ovp_i,
  input  wire       charge_enable_n_i,
  input  wire       charge_inhibit_i,
  input  wire       vbat_above_trickle_exit_i,
  input  wire       vbat_above_precharge_exit_i,
  input  wire       vbat_below_recharge_i,
  input  wire       vbat_below_uv_i,
  input  wire       cv_loop_active_i,
  input  wire       fast_charge_current_below_term_i,
  input  wire       input_loop_active_i,
  input  wire       system_loop_active_i,
  input  wire       thermal_reg_active_i,
  input  wire       thermistor_fault_i,
  input  wire       battery_only_i,
  input  wire       overcurrent_i,
  input  wire       ship_mode_i,
  input  wire       wake_request_i,
  input  wire       i2c_activity_i,
  input  wire       wdog_kick_i,
  input  wire [1:0] wdog_sel_i,
  input  wire [1:0] term_threshold_sel_i,
  input  wire [6:0] battery_reg_voltage_i,
  input  wire [9:0] safety_minutes_i,
  output reg        battery_switch_on_o,
  output reg  [2:0] charge_phase_o,
  output reg  [1:0] term_pct_sel_o,
  output reg        current_reduced_o,
  output reg  [6:0] vreg_target_o,
  output reg        charge_done_o,
  output reg        safety_fault_o,
  output reg        ovp_fault_o,
  output reg        sleep_o,
  output reg        ship_exit_o,
  output reg        ocp_recovering_o,
  output reg        ocp_retry_ok_o,
  output reg        thermistor_sense_en_o,
  output reg        wdog_expired_o,
  output reg        i2c_reset_o
);

  // Phase encodings, also visible on charge_phase_o
  localparam [2:0] ST_IDLE    = 3'h0;
  localparam [2:0] ST_TRICKLE = 3'h1;
  localparam [2:0] ST_PRECHG  = 3'h2;
  localparam [2:0] ST_FAST    = 3'h3;
  localparam [2:0] ST_DONE    = 3'h4;
  localparam [2:0] ST_FAULT   = 3'h5;

  // Derived counts, all from the 1 us or 1 ms ticks
  localparam [19:0] SLEEP_DGL = `SLEEP_DGL_US;
  localparam [19:0] BATTERY_UNDERVOLTAGE_LEVEL_DGL = `BATTERY_UNDERVOLTAGE_LEVEL_DGL_US;
  localparam [19:0] OVPZ_DGL  = `OVPZ_DGL_MS;
  localparam [19:0] WAKE_MIN  = `VIN_WAKE_MS;
  localparam [19:0] SHIP_WAKE = `SHIP_WAKE_MS;
  localparam [11:0] REC_SC    = `REC_SC_MS;
  localparam [11:0] RETRY_SC  = `RETRY_SC_MS;
  localparam [7:0]  TS_ON     = `TS_ON_MS;
  localparam [7:0]  TS_OFF    = `TS_OFF_MS;
  localparam [8:0]  I2C_IDLE  = `I2C_IDLE_MS;
  localparam [17:0] WDOG_S    = `WDOG_SHORT_S * 1000;
  localparam [17:0] WDOG_L    = `WDOG_LONG_S * 1000;

  wire us_tick;
  wire ms_tick;
  wire ovp_ok_dg;
  wire sleep_dg;
  wire uv_dg;
  wire vin_stable;
  wire wake_dg;

  tick_gen u_tick (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .us_tick_o (us_tick),
    .ms_tick_o (ms_tick)
  );

  // Overvoltage blocks at once; its clear needs 30 ms of falling input
  reg        ovp_q;
  reg [19:0] ovp_cnt_q;
  always @(posedge clock_i) begin
    if (rst_i) begin
      ovp_q     <= 1'b0;
      ovp_cnt_q <= 20'h00000;
    end else if (!vin_below_ovp_i) begin
      ovp_q     <= 1'b1;
      ovp_cnt_q <= 20'h00000;
    end else if (ovp_q && ms_tick) begin
      if (ovp_cnt_q >= OVPZ_DGL - 20'h00001) begin
        ovp_q     <= 1'b0;
        ovp_cnt_q <= 20'h00000;
      end else begin
        ovp_cnt_q <= ovp_cnt_q + 20'h00001;
      end
    end
  end
  assign ovp_ok_dg = vin_below_ovp_i & ~ovp_q;

  // Sleep condition must persist 64 us
  deglitch #(.LEN(SLEEP_DGL)) u_sleep (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tick_i  (us_tick),
    .level_i (~vin_above_sleep_i),
    .level_o (sleep_dg)
  );

  // Undervoltage must persist 60 us before the switch opens
  deglitch #(.LEN(BATTERY_UNDERVOLTAGE_LEVEL_DGL)) u_uv (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tick_i  (us_tick),
    .level_i (vbat_below_uv_i),
    .level_o (uv_dg)
  );

  // Input must be present 10 ms for ship exit
  deglitch #(.LEN(WAKE_MIN)) u_vin_wake (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tick_i  (ms_tick),
    .level_i (vin_above_sleep_i),
    .level_o (vin_stable)
  );

  // Wake request qualified by 2 s
  deglitch #(.LEN(SHIP_WAKE)) u_ship_wake (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tick_i  (ms_tick),
    .level_i (wake_request_i),
    .level_o (wake_dg)
  );

  // Input qualification and charge permission
  wire vin_valid = vin_above_loop_i & ~sleep_dg & ovp_ok_dg;
  wire permit    = vin_valid & ~charge_enable_n_i & ~charge_inhibit_i;
  wire loops_reduce = input_loop_active_i | system_loop_active_i | thermal_reg_active_i;
  wire term_enabled = (term_threshold_sel_i != `TERM_SEL_OFF);
  wire term_hit = cv_loop_active_i & ~loops_reduce & fast_charge_current_below_term_i & term_enabled;

  // Safety budget in ms: fast limit and precharge quarter
  wire [25:0] fast_budget = {16'h0000, safety_minutes_i} * 26'h000EA60;
  wire [25:0] pre_budget  = fast_budget >> `PRECHG_SHIFT;

  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg [25:0] safety_cnt_q;
  reg [25:0] pre_cnt_q;

  // Phase selection
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (permit) begin
          if (!vbat_above_trickle_exit_i) begin
            state_d = ST_TRICKLE;
          end else if (!vbat_above_precharge_exit_i) begin
            state_d = ST_PRECHG;
          end else begin
            state_d = ST_FAST;
          end
        end
      end
      ST_TRICKLE: begin
        if (vbat_above_trickle_exit_i) begin
          state_d = ST_PRECHG;
        end
      end
      ST_PRECHG: begin
        if (vbat_above_precharge_exit_i) begin
          state_d = ST_FAST;
        end
      end
      ST_FAST: begin
        if (term_hit) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (vbat_below_recharge_i) begin
          state_d = ST_IDLE;
        end
      end
      ST_FAULT: begin
        state_d = ST_FAULT;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Precharge budget exhausted in trickle or precharge
    if ((state_q == ST_TRICKLE || state_q == ST_PRECHG) && pre_cnt_q >= pre_budget) begin
      state_d = ST_FAULT;
    end
    if (state_q == ST_FAST && safety_cnt_q >= fast_budget) begin
      state_d = ST_FAULT;
    end
    // Losing permission drops to idle except from done; fault held until input removal
    if (!permit && state_q != ST_FAULT && state_q != ST_DONE) begin
      state_d = ST_IDLE;
    end
    if (state_q == ST_FAULT && !vin_valid) begin
      state_d = ST_IDLE;
    end
  end

  // Phase register and safety timers; recharge restarts both timers
  always @(posedge clock_i) begin
    if (rst_i) begin
      state_q      <= ST_IDLE;
      safety_cnt_q <= 26'h0000000;
      pre_cnt_q    <= 26'h0000000;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE || state_q == ST_DONE) begin
        safety_cnt_q <= 26'h0000000;
        pre_cnt_q    <= 26'h0000000;
      end else if (ms_tick) begin
        safety_cnt_q <= safety_cnt_q + 26'h0000001;
        if (state_q == ST_TRICKLE || state_q == ST_PRECHG) begin
          pre_cnt_q <= pre_cnt_q + 26'h0000001;
        end
      end
    end
  end

  // Charge outputs; regulation target clamp
  always @(posedge clock_i) begin
    if (rst_i) begin
      battery_switch_on_o <= 1'b0;
      charge_phase_o      <= ST_IDLE;
      term_pct_sel_o      <= `TERM_SEL_OFF;
      current_reduced_o   <= 1'b0;
      vreg_target_o       <= 7'h00;
      charge_done_o       <= 1'b0;
      safety_fault_o      <= 1'b0;
    end else begin
      // Switch stays open in done, fault, idle and deglitched undervoltage
      battery_switch_on_o <= permit & ~uv_dg & (state_d == ST_TRICKLE || state_d == ST_PRECHG
                             || state_d == ST_FAST);
      charge_phase_o    <= state_d;
      term_pct_sel_o    <= term_threshold_sel_i;
      current_reduced_o <= thermistor_fault_i | loops_reduce;
      if (battery_reg_voltage_i > `VREG_CODE_MAX) begin
        vreg_target_o <= `VREG_CODE_MAX;
      end else begin
        vreg_target_o <= battery_reg_voltage_i;
      end
      // Done flag held until a new cycle begins
      if (state_d == ST_DONE) begin
        charge_done_o <= 1'b1;
      end else if (state_d != ST_IDLE) begin
        charge_done_o <= 1'b0;
      end
      safety_fault_o <= (state_d == ST_FAULT);
    end
  end

  // Input supervision and ship exit
  always @(posedge clock_i) begin
    if (rst_i) begin
      ovp_fault_o <= 1'b0;
      sleep_o     <= 1'b0;
      ship_exit_o <= 1'b0;
    end else begin
      ovp_fault_o <= ~ovp_ok_dg;
      sleep_o     <= sleep_dg;
      ship_exit_o <= ship_mode_i & (vin_stable | wake_dg);
    end
  end

  // Overcurrent recovery wait and retry window, both in ms
  reg [11:0] rec_cnt_q;
  reg [11:0] retry_cnt_q;
  always @(posedge clock_i) begin
    if (rst_i) begin
      rec_cnt_q        <= 12'h000;
      retry_cnt_q      <= 12'h000;
      ocp_recovering_o <= 1'b0;
      ocp_retry_ok_o   <= 1'b1;
    end else begin
      if (overcurrent_i) begin
        rec_cnt_q        <= REC_SC;
        ocp_recovering_o <= 1'b1;
        if (retry_cnt_q == 12'h000) begin
          retry_cnt_q    <= RETRY_SC;
          ocp_retry_ok_o <= 1'b0;
        end
      end else if (ms_tick) begin
        if (rec_cnt_q != 12'h000) begin
          rec_cnt_q <= rec_cnt_q - 12'h001;
        end
        ocp_recovering_o <= (rec_cnt_q > 12'h001);
        if (retry_cnt_q != 12'h000) begin
          retry_cnt_q <= retry_cnt_q - 12'h001;
        end
        ocp_retry_ok_o <= (retry_cnt_q <= 12'h001);
      end
    end
  end

  // Thermistor duty cycle, battery-only mode; always on otherwise
  reg [7:0] ts_cnt_q;
  reg       ts_on_q;
  always @(posedge clock_i) begin
    if (rst_i) begin
      ts_cnt_q              <= 8'h00;
      ts_on_q               <= 1'b1;
      thermistor_sense_en_o <= 1'b1;
    end else begin
      if (!battery_only_i) begin
        ts_cnt_q <= 8'h00;
        ts_on_q  <= 1'b1;
      end else if (ms_tick) begin
        if (ts_on_q && ts_cnt_q >= TS_ON - 8'h01) begin
          ts_on_q  <= 1'b0;
          ts_cnt_q <= 8'h00;
        end else if (!ts_on_q && ts_cnt_q >= TS_OFF - 8'h01) begin
          ts_on_q  <= 1'b1;
          ts_cnt_q <= 8'h00;
        end else begin
          ts_cnt_q <= ts_cnt_q + 8'h01;
        end
      end
      thermistor_sense_en_o <= ~battery_only_i | ts_on_q;
    end
  end

  // Watchdog and interface idle timers; a kick or traffic restarts them
  reg [17:0] wdog_cnt_q;
  reg [8:0]  idle_cnt_q;
  wire       wdog_off = (wdog_sel_i != `WDOG_SEL_40S) && (wdog_sel_i != `WDOG_SEL_160S);
  wire [17:0] wdog_lim = (wdog_sel_i == `WDOG_SEL_40S) ? WDOG_S : WDOG_L;
  always @(posedge clock_i) begin
    if (rst_i) begin
      wdog_cnt_q     <= 18'h00000;
      idle_cnt_q     <= 9'h000;
      wdog_expired_o <= 1'b0;
      i2c_reset_o    <= 1'b0;
    end else begin
      wdog_expired_o <= 1'b0;
      i2c_reset_o    <= 1'b0;
      if (wdog_kick_i || wdog_off) begin
        wdog_cnt_q <= 18'h00000;
      end else if (ms_tick) begin
        if (wdog_cnt_q >= wdog_lim - 18'h00001) begin
          wdog_cnt_q     <= 18'h00000;
          wdog_expired_o <= 1'b1;
        end else begin
          wdog_cnt_q <= wdog_cnt_q + 18'h00001;
        end
      end
      if (i2c_activity_i) begin
        idle_cnt_q <= 9'h000;
      end else if (ms_tick) begin
        if (idle_cnt_q >= I2C_IDLE - 9'h001) begin
          idle_cnt_q  <= 9'h000;
          i2c_reset_o <= 1'b1;
        end else begin
          idle_cnt_q <= idle_cnt_q + 9'h001;
        end
      end
    end
  end

endmodule

// *** verif/charge_seq_assertions.sv ***
`timescale 1ns/1ps
module charge_seq_checker (
  input wire       clock_i,
  input wire       rst_i,
  input wire       vin_above_loop_i,
  input wire       vin_above_sleep_i,
  input wire       charge_enable_n_i,
  input wire       charge_inhibit_i,
  input wire       vbat_above_precharge_exit_i,
  input wire       vbat_below_uv_i,
  input wire       cv_loop_active_i,
  input wire       fast_charge_current_below_term_i,
  input wire       input_loop_active_i,
  input wire       system_loop_active_i,
  input wire       thermal_reg_active_i,
  input wire [1:0] term_threshold_sel_i,
  input wire [6:0] battery_reg_voltage_i,
  input wire       battery_switch_on_o,
  input wire [2:0] charge_phase_o,
  input wire [1:0] term_pct_sel_o,
  input wire [6:0] vreg_target_o,
  input wire       charge_done_o,
  input wire       sleep_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  logic [13:0] slp_q;
  logic [13:0] uv_q;
  logic        term_ok_q;

  // Run lengths of the slow conditions; saturate so a long stay never wraps
  always @(posedge clock_i) begin
    if (rst_i || vin_above_sleep_i) slp_q <= 14'h0000;
    else if (slp_q != 14'h3FFF) slp_q <= slp_q + 14'h0001;
    if (rst_i || !vbat_below_uv_i) uv_q <= 14'h0000;
    else if (uv_q != 14'h3FFF) uv_q <= uv_q + 14'h0001;
    term_ok_q <= !rst_i && cv_loop_active_i && fast_charge_current_below_term_i && (term_threshold_sel_i != 2'h0)
                 && !(input_loop_active_i || system_loop_active_i || thermal_reg_active_i);
  end

  a_enable_refuse: assert property (charge_enable_n_i |=> !battery_switch_on_o)
    else $error("switch on with enable pin high");
  a_inhibit_refuse: assert property (charge_inhibit_i |=> !battery_switch_on_o)
    else $error("switch on with inhibit set");
  a_input_refuse: assert property (!vin_above_loop_i |=> !battery_switch_on_o)
    else $error("switch on without valid input");
  a_vreg_clamp: assert property ((battery_reg_voltage_i > 7'h73) [*2] |-> vreg_target_o == 7'h73)
    else $error("target not clamped");
  a_vreg_pass: assert property ((battery_reg_voltage_i <= 7'h73) [*2] ##0 $stable(battery_reg_voltage_i)
    |-> vreg_target_o == battery_reg_voltage_i)
    else $error("target differs from code");
  a_term_copy: assert property (1'b1 |=> term_pct_sel_o == $past(term_threshold_sel_i))
    else $error("termination select not followed");
  a_sleep_early: assert property ($rose(sleep_o) |-> slp_q >= 14'h1E78)
    else $error("sleep entered too soon");
  a_sleep_late: assert property (slp_q == 14'h206C |-> sleep_o)
    else $error("sleep entry late");
  a_uv_open: assert property (uv_q == 14'h1E14 |-> !battery_switch_on_o)
    else $error("switch still on under undervoltage");
  a_done_cause: assert property ($rose(charge_done_o) |-> term_ok_q)
    else $error("done without clean termination");
  a_done_opens: assert property ($rose(charge_done_o) |-> !battery_switch_on_o)
    else $error("switch on at termination");
  a_fast_entry: assert property ($changed(charge_phase_o) && charge_phase_o == 3'h3
    |-> $past(vbat_above_precharge_exit_i))
    else $error("fast charge below exit level");

  c_sleep: cover property ($rose(sleep_o));
  c_clamp: cover property (battery_reg_voltage_i > 7'h73 ##1 vreg_target_o == 7'h73);
  c_refuse: cover property (charge_enable_n_i ##1 !battery_switch_on_o);
endmodule

bind linear_charge_sequencer charge_seq_checker u_chk (.*);

// *** verif/batt_model.sv ***
`timescale 1ns/1ps
module batt_model #(
  parameter [12:0] TRICKLE_MV = 13'h0898,
  parameter [12:0] PRECHG_MV  = 13'h0BB8,
  parameter [12:0] UV_MV      = 13'h0A8C,
  parameter [12:0] RCH_MV     = 13'h0064
) (
  input  wire        clock_i,
  input  wire [12:0] vbat_mv_i,
  input  wire [6:0]  vreg_code_i,
  output reg         above_trickle_o,
  output reg         above_prechg_o,
  output reg         below_rch_o,
  output reg         below_uv_o
);
  // Regulation target in mV: 3.5 V base, 10 mV steps
  wire [12:0] vreg_mv = 13'h0DAC + 13'(vreg_code_i) * 13'h000A;

  initial {above_trickle_o, above_prechg_o, below_rch_o, below_uv_o} = 4'h0;

  // Comparators land on the clock edge, as the sequencer expects synchronous flags
  always @(posedge clock_i) begin
    above_trickle_o <= vbat_mv_i >= TRICKLE_MV;
    above_prechg_o  <= vbat_mv_i >= PRECHG_MV;
    below_rch_o     <= vbat_mv_i < vreg_mv - RCH_MV;
    below_uv_o      <= vbat_mv_i < UV_MV;
  end
endmodule

// *** verif/tb_linear_charge_sequencer.sv ***
`timescale 1ns/1ps
module tb_linear_charge_sequencer;
  logic        clock_i = 1'b0, rst_i = 1'b1;
  logic        vin_above_loop_i = 1'b1, vin_above_sleep_i = 1'b1, vin_below_ovp_i = 1'b1;
  logic        charge_enable_n_i = 1'b0, charge_inhibit_i = 1'b0, battery_only_i = 1'b0;
  logic [10:0] misc = 11'h000;
  logic [1:0]  wdog_sel_i = 2'h2, term_threshold_sel_i = 2'h0;
  logic [6:0]  battery_reg_voltage_i = 7'h46;
  logic [9:0]  safety_minutes_i = 10'h0B4;
  logic [12:0] vbat_mv = 13'h0E10;
  logic [6:0]  vtab [5] = '{7'h00, 7'h72, 7'h73, 7'h74, 7'h7F};
  wire         cv_loop_active_i, fast_charge_current_below_term_i, input_loop_active_i, system_loop_active_i;
  wire         thermal_reg_active_i, thermistor_fault_i, overcurrent_i, ship_mode_i;
  wire         wake_request_i, i2c_activity_i, wdog_kick_i;
  wire         vbat_above_trickle_exit_i, vbat_above_precharge_exit_i, vbat_below_recharge_i, vbat_below_uv_i;
  wire         battery_switch_on_o, current_reduced_o, charge_done_o, safety_fault_o, ovp_fault_o;
  wire         sleep_o, ship_exit_o, ocp_recovering_o, ocp_retry_ok_o, thermistor_sense_en_o;
  wire         wdog_expired_o, i2c_reset_o;
  wire [2:0]   charge_phase_o;
  wire [1:0]   term_pct_sel_o;
  wire [6:0]   vreg_target_o;
  int          fails = 0, comparisons = 0, n;

  // Loop and event flags share one vector so a loop can walk them all
  assign {cv_loop_active_i, fast_charge_current_below_term_i, input_loop_active_i, system_loop_active_i,
          thermal_reg_active_i, thermistor_fault_i, overcurrent_i, ship_mode_i,
          wake_request_i, i2c_activity_i, wdog_kick_i} = misc;

  always #4 clock_i = ~clock_i;

  linear_charge_sequencer uut (.*);

  batt_model u_batt (
    .clock_i         (clock_i),
    .vbat_mv_i       (vbat_mv),
    .vreg_code_i     (battery_reg_voltage_i),
    .above_trickle_o (vbat_above_trickle_exit_i),
    .above_prechg_o  (vbat_above_precharge_exit_i),
    .below_rch_o     (vbat_below_recharge_i),
    .below_uv_o      (vbat_below_uv_i)
  );

  // Inputs move 1 ns after the edge so no race with the design's sampling
  task step(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask

  task check(input [15:0] got, input [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task results;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence; the 30 ms overvoltage clear applies only after an overvoltage, so charging can start once enabled
  initial begin
    step(5);
    check(battery_switch_on_o, 1'b0);
    check(charge_phase_o, 3'h0);
    check(ocp_retry_ok_o, 1'b1);
    check(thermistor_sense_en_o, 1'b1);
    rst_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      term_threshold_sel_i = i[1:0];
      wdog_sel_i = i[1:0];
      step(2);
      check(term_pct_sel_o, i[1:0]);
    end
    for (int i = 0; i < 5; i++) begin
      battery_reg_voltage_i = vtab[i];
      step(2);
      check(vreg_target_o, (vtab[i] > 7'h73) ? 7'h73 : vtab[i]);
    end
    // Trickle, precharge and fast phases follow the battery level
    charge_enable_n_i = 1'b1;
    battery_reg_voltage_i = 7'h46;
    vbat_mv = 13'h0800;
    step(2);
    charge_enable_n_i = 1'b0;
    step(3);
    check(charge_phase_o, 3'h1);
    check(battery_switch_on_o, 1'b1);
    vbat_mv = 13'h0AF0;
    step(3);
    check(charge_phase_o, 3'h2);
    vbat_mv = 13'h1068;
    step(3);
    check(charge_phase_o, 3'h3);
    // A reducing loop blocks termination; CV with current below termination terminates
    misc = 11'h700;
    step(3);
    check(current_reduced_o, 1'b1);
    check(charge_phase_o, 3'h3);
    misc = 11'h600;
    step(2);
    check(charge_phase_o, 3'h4);
    check(charge_done_o, 1'b1);
    check(battery_switch_on_o, 1'b0);
    misc = 11'h000;
    vbat_mv = 13'h0E10;
    step(4);
    check(charge_phase_o, 3'h3);
    check(charge_done_o, 1'b0);
    // Enable pin high: no flag may turn the switch on
    charge_enable_n_i = 1'b1;
    for (int i = 0; i < 11; i++) begin
      misc = 11'h001 << i;
      step(3);
      check(battery_switch_on_o, 1'b0);
      check(charge_phase_o, 3'h0);
    end
    misc = 11'h000;
    check(ocp_recovering_o, 1'b1);
    check(ocp_retry_ok_o, 1'b0);
    charge_enable_n_i = 1'b0;
    charge_inhibit_i = 1'b1;
    step(3);
    check(battery_switch_on_o, 1'b0);
    charge_inhibit_i = 1'b0;
    vin_above_loop_i = 1'b0;
    step(3);
    check(charge_phase_o, 3'h0);
    vin_above_loop_i = 1'b1;
    // Sleep must wait out its deglitch, then follow within 600 cycles
    vin_above_sleep_i = 1'b0;
    step(7790);
    check(sleep_o, 1'b0);
    n = 0;
    while (sleep_o !== 1'b1 && n < 600) begin
      step(1);
      n++;
    end
    if (n == 600) begin
      fails++;
      results;
    end
    check(sleep_o, 1'b1);
    vin_above_sleep_i = 1'b1;
    vbat_mv = 13'h0A00;
    step(7800);
    check(battery_switch_on_o, 1'b0);
    vbat_mv = 13'h0E10;
    battery_only_i = 1'b1;
    step(1000);
    check(thermistor_sense_en_o, 1'b1);
    vin_below_ovp_i = 1'b0;
    step(3);
    check(ovp_fault_o, 1'b1);
    check(battery_switch_on_o, 1'b0);
    results;
  end
endmodule
